// [design/pss_pkg.sv]
// shared constants and types for the program sequencer
package pss_pkg;
  localparam int PC_W = 12;
  localparam int WORD_W = 15;
  localparam logic [3:0] STK_DEPTH = 4'h8;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] VEC_USB = 12'h004;
  localparam logic [11:0] VEC_TMR0 = 12'h008;
  localparam logic [11:0] VEC_TMR1 = 12'h00C;
  localparam logic [7:0] OFS_PCL = 8'h00;
  localparam logic [7:0] OFS_SEQ_STAT = 8'h04;
  localparam logic [7:0] OFS_ALU_STAT = 8'h08;
  localparam int FLG_C = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int ST_PEND_LSB = 4;
  localparam int ST_PCL_PEND = 7;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [2:0] IRQ_USB = 3'h1;
  localparam logic [2:0] IRQ_TMR0 = 3'h2;
  localparam logic [2:0] IRQ_TMR1 = 3'h4;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } pss_phase_e;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ADD = 4'h1, OP_ADC = 4'h2, OP_SUB = 4'h3,
    OP_SBC = 4'h4, OP_DAA = 4'h5, OP_AND = 4'h6, OP_OR = 4'h7,
    OP_XOR = 4'h8, OP_CPL = 4'h9, OP_RR = 4'hA, OP_RRC = 4'hB,
    OP_RL = 4'hC, OP_RLC = 4'hD, OP_INC = 4'hE, OP_DEC = 4'hF
  } pss_alu_op_e;

  typedef struct packed {
    logic jump;
    logic call;
    logic return_from_call;
    logic return_from_interrupt;
    logic skip;
    logic [11:0] target;
    pss_alu_op_e op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic to_mem;
  } pss_cmd_s;
endpackage : pss_pkg

// [design/pss_sequencer.sv]
// program sequencer: phases, program counter, return stack, vectors, alu
// Function
// - four phases form one instruction cycle
// - pc advances and fetch starts at T1
// - fetch overlaps execution of current instruction
// - branches take two instruction cycles
// - pc increments unless control is redirected
// - only pc low byte visible to software
// - taken skip discards prefetch, pc plus two
// - pc low write keeps page, adds dummy
// - jump and call load twelve target bits
// - eight-entry hidden return stack
// - call/interrupt push, returns pop into pc
// - reset points stack pointer at top
// - reset clears pc to zero
// - full stack holds interrupt until return
// - call on full stack still executes
// - usb interrupt vectors to 004H
// - timer vectors 008H and 00CH
// - alu writes result and updates status
// - alu arithmetic, logic, rotate, inc, dec
// - pc addresses 4K by 15 memory
`timescale 1ns/100ps
module pss_sequencer (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [pss_pkg::WORD_W-1:0] prog_data_in,
  input wire pss_pkg::pss_cmd_s cmd_in,
  input wire logic [2:0] irq_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [pss_pkg::PC_W-1:0] prog_addr_out,
  output logic [pss_pkg::WORD_W-1:0] exec_word_out,
  output logic exec_valid_out,
  output logic [3:0] phase_out,
  output logic [7:0] alu_result_out,
  output logic alu_wr_out,
  output logic alu_to_mem_out,
  output logic [2:0] irq_ack_out
);
  import pss_pkg::*;

  pss_phase_e phase_reg, phase_next;
  logic [11:0] pc_reg, pc_next;
  logic [14:0] word_reg, word_next;
  logic valid_reg, valid_next;
  logic [11:0] stack_reg [8];
  logic [11:0] stack_next [8];
  logic [2:0] sp_reg, sp_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] pend_reg, pend_next;
  logic [2:0] ack_reg, ack_next;
  logic pcl_pend_reg, pcl_pend_next;
  logic [7:0] pcl_val_reg, pcl_val_next;
  logic [3:0] flags_reg, flags_next;
  logic [7:0] res_reg, res_next;
  logic alu_wr_reg, alu_wr_next;
  logic to_mem_reg, to_mem_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic at_t4, ex, full, access, done;
  logic [2:0] irq_sel;
  logic [11:0] vec;
  logic [8:0] sum;
  logic [4:0] hs;
  logic cin;
  logic [7:0] r;

  assign at_t4 = (phase_reg == PH_T4);
  assign ex = valid_reg;
  assign full = (cnt_reg == STK_DEPTH);
  assign access = psel_in && penable_in;
  assign done = access && pready_reg;
  // fixed priority: usb, then timer 0, then timer 1
  assign irq_sel = pend_reg[0] ? IRQ_USB : pend_reg[1] ? IRQ_TMR0 :
                   pend_reg[2] ? IRQ_TMR1 : 3'h0;
  assign vec = pend_reg[0] ? VEC_USB : pend_reg[1] ? VEC_TMR0 : VEC_TMR1;

  always_comb begin
    unique case (phase_reg)
      PH_T1: phase_next = PH_T2;
      PH_T2: phase_next = PH_T3;
      PH_T3: phase_next = PH_T4;
      PH_T4: phase_next = PH_T1;
      default: phase_next = PH_T1;
    endcase
    pc_next = pc_reg;
    word_next = word_reg;
    valid_next = valid_reg;
    stack_next = stack_reg;
    sp_next = sp_reg;
    cnt_next = cnt_reg;
    ack_next = 3'h0;
    pcl_pend_next = pcl_pend_reg;
    pcl_val_next = pcl_val_reg;
    flags_next = flags_reg;
    res_next = res_reg;
    alu_wr_next = 1'b0;
    to_mem_next = to_mem_reg;
    sum = 9'h000;
    hs = 5'h00;
    cin = 1'b0;
    r = 8'h00;
    if (at_t4) begin
      // the word fetched during this cycle executes in the next one
      pc_next = 12'(pc_reg + 12'h001);
      word_next = prog_data_in;
      valid_next = 1'b1;
      if (ex && (cmd_in.jump || cmd_in.call)) begin
        pc_next = cmd_in.target;
        valid_next = 1'b0;
        if (cmd_in.call) begin
          // on a full stack the oldest entry is lost; the call still runs
          stack_next[sp_reg] = pc_reg;
          sp_next = 3'(sp_reg + 3'h1);
          cnt_next = full ? cnt_reg : 4'(cnt_reg + 4'h1);
        end
      end else if (ex && (cmd_in.return_from_call || cmd_in.return_from_interrupt)) begin
        pc_next = stack_reg[3'(sp_reg - 3'h1)];
        sp_next = 3'(sp_reg - 3'h1);
        cnt_next = (cnt_reg == 4'h0) ? 4'h0 : 4'(cnt_reg - 4'h1);
        valid_next = 1'b0;
      end else if (ex && cmd_in.skip) begin
        valid_next = 1'b0;
      end else if (pcl_pend_reg) begin
        pc_next = {pc_reg[11:8], pcl_val_reg};
        valid_next = 1'b0;
        pcl_pend_next = 1'b0;
      end else if (irq_sel != 3'h0 && !full) begin
        stack_next[sp_reg] = pc_reg;
        sp_next = 3'(sp_reg + 3'h1);
        cnt_next = 4'(cnt_reg + 4'h1);
        pc_next = vec;
        valid_next = 1'b0;
        ack_next = irq_sel;
      end
      if (ex && cmd_in.op != OP_NONE) begin
        alu_wr_next = 1'b1;
        to_mem_next = cmd_in.to_mem;
        unique case (cmd_in.op)
          OP_ADD, OP_ADC: begin
            cin = (cmd_in.op == OP_ADC) && flags_reg[FLG_C];
            sum = 9'({1'b0, cmd_in.opa} + {1'b0, cmd_in.opb} + {8'h00, cin});
            hs = 5'({1'b0, cmd_in.opa[3:0]} + {1'b0, cmd_in.opb[3:0]} + {4'h0, cin});
            r = sum[7:0];
            flags_next[FLG_C] = sum[8];
            flags_next[FLG_AC] = hs[4];
            flags_next[FLG_OV] = (cmd_in.opa[7] == cmd_in.opb[7]) && (r[7] != cmd_in.opa[7]);
          end
          OP_SUB, OP_SBC: begin
            // carry set means no borrow
            cin = (cmd_in.op == OP_SBC) && !flags_reg[FLG_C];
            sum = 9'({1'b0, cmd_in.opa} - {1'b0, cmd_in.opb} - {8'h00, cin});
            hs = 5'({1'b0, cmd_in.opa[3:0]} - {1'b0, cmd_in.opb[3:0]} - {4'h0, cin});
            r = sum[7:0];
            flags_next[FLG_C] = !sum[8];
            flags_next[FLG_AC] = !hs[4];
            flags_next[FLG_OV] = (cmd_in.opa[7] != cmd_in.opb[7]) && (r[7] != cmd_in.opa[7]);
          end
          OP_DAA: begin
            sum = {1'b0, cmd_in.opa};
            if (cmd_in.opa[3:0] > 4'h9 || flags_reg[FLG_AC]) begin
              sum = 9'(sum + 9'h006);
            end
            if (sum[8:4] > 5'h09 || flags_reg[FLG_C]) begin
              sum = 9'(sum + 9'h060);
            end
            r = sum[7:0];
            flags_next[FLG_C] = sum[8] || flags_reg[FLG_C];
          end
          OP_AND: r = cmd_in.opa & cmd_in.opb;
          OP_OR: r = cmd_in.opa | cmd_in.opb;
          OP_XOR: r = cmd_in.opa ^ cmd_in.opb;
          OP_CPL: r = ~cmd_in.opa;
          OP_RR: r = {cmd_in.opa[0], cmd_in.opa[7:1]};
          OP_RRC: begin
            r = {flags_reg[FLG_C], cmd_in.opa[7:1]};
            flags_next[FLG_C] = cmd_in.opa[0];
          end
          OP_RL: r = {cmd_in.opa[6:0], cmd_in.opa[7]};
          OP_RLC: begin
            r = {cmd_in.opa[6:0], flags_reg[FLG_C]};
            flags_next[FLG_C] = cmd_in.opa[7];
          end
          OP_INC: r = 8'(cmd_in.opa + 8'h01);
          OP_DEC: r = 8'(cmd_in.opa - 8'h01);
          default: r = 8'h00;
        endcase
        // rotations leave zero untouched
        if (!(cmd_in.op inside {OP_RR, OP_RRC, OP_RL, OP_RLC})) begin
          flags_next[FLG_Z] = (r == 8'h00);
        end
        res_next = r;
      end
    end
    // a request arriving as its flag is acknowledged is kept
    pend_next = (pend_reg & ~ack_next) | irq_in;
    // apb slave: one wait state, registered answer
    pready_next = access && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (access && !pready_reg) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr_in)
        OFS_PCL: prdata_next[7:0] = pc_reg[7:0];
        OFS_SEQ_STAT: begin
          prdata_next[3:0] = cnt_reg;
          prdata_next[ST_PEND_LSB +: 3] = pend_reg;
          prdata_next[ST_PCL_PEND] = pcl_pend_reg;
        end
        OFS_ALU_STAT: prdata_next[3:0] = flags_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
    if (done && pwrite_in) begin
      if (paddr_in == OFS_PCL) begin
        pcl_pend_next = 1'b1;
        pcl_val_next = pwdata_in[7:0];
      end
      // software write yields to a same-cycle alu update
      if (paddr_in == OFS_ALU_STAT && !alu_wr_next) begin
        flags_next = pwdata_in[3:0];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      phase_reg <= PH_T1;
      pc_reg <= PC_RESET;
      word_reg <= 15'h0000;
      valid_reg <= 1'b0;
      sp_reg <= 3'h0;
      cnt_reg <= 4'h0;
      pend_reg <= 3'h0;
      ack_reg <= 3'h0;
      pcl_pend_reg <= 1'b0;
      pcl_val_reg <= 8'h00;
      flags_reg <= FLAGS_RESET;
      res_reg <= 8'h00;
      alu_wr_reg <= 1'b0;
      to_mem_reg <= 1'b0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      phase_reg <= phase_next;
      pc_reg <= pc_next;
      word_reg <= word_next;
      valid_reg <= valid_next;
      sp_reg <= sp_next;
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
      ack_reg <= ack_next;
      pcl_pend_reg <= pcl_pend_next;
      pcl_val_reg <= pcl_val_next;
      flags_reg <= flags_next;
      res_reg <= res_next;
      alu_wr_reg <= alu_wr_next;
      to_mem_reg <= to_mem_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // stack contents need no reset; unreadable until pushed
  always_ff @(posedge mclk_in) begin
    stack_reg <= stack_next;
  end

  assign prog_addr_out = pc_reg;
  assign exec_word_out = word_reg;
  assign exec_valid_out = valid_reg;
  assign phase_out = phase_reg;
  assign alu_result_out = res_reg;
  assign alu_wr_out = alu_wr_reg;
  assign alu_to_mem_out = to_mem_reg;
  assign irq_ack_out = ack_reg;
  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_phase_walk: assert property (phase_reg == PH_T1 |=> phase_reg == PH_T2 ##1
    phase_reg == PH_T3 ##1 phase_reg == PH_T4 ##1 phase_reg == PH_T1)
    else $error("phase sequence broken");
  a_pc_hold_mid: assert property (!at_t4 |=> $stable(pc_reg))
    else $error("pc changed outside T1 start");
  a_pc_plain_inc: assert property (at_t4 && !ex && !pcl_pend_reg && irq_sel == 3'h0
    |=> pc_reg == 12'($past(pc_reg) + 12'h001))
    else $error("pc not incremented");
  // an interrupt or a waiting pc low load may claim the slot after the dummy
  a_jump_target: assert property (at_t4 && ex && cmd_in.jump
    |=> pc_reg == $past(cmd_in.target) && !valid_reg ##4
    (valid_reg || irq_ack_out != 3'h0 || $past(pcl_pend_reg)))
    else $error("jump target or dummy wrong");
  a_skip_dummy: assert property (at_t4 && ex && cmd_in.skip && !cmd_in.jump && !cmd_in.call
    && !cmd_in.return_from_call && !cmd_in.return_from_interrupt
    |=> !valid_reg && pc_reg == 12'($past(pc_reg) + 12'h001))
    else $error("skip did not discard prefetch");
  a_pcl_page: assert property (at_t4 && pcl_pend_reg && !ex
    |=> pc_reg[11:8] == $past(pc_reg[11:8]) && pc_reg[7:0] == $past(pcl_val_reg))
    else $error("pc low load left its page");
  a_stack_bound: assert property (cnt_reg <= STK_DEPTH)
    else $error("stack count beyond depth");
  a_irq_hold: assert property (at_t4 && full |=> irq_ack_out == 3'h0)
    else $error("interrupt acknowledged on full stack");
  a_usb_vector: assert property (irq_ack_out == IRQ_USB |-> pc_reg == VEC_USB)
    else $error("usb vector wrong");
  a_tmr_vector: assert property (irq_ack_out == IRQ_TMR1 |-> pc_reg == VEC_TMR1)
    else $error("timer 1 vector wrong");
  a_call_return: assert property (at_t4 && ex && cmd_in.call && !cmd_in.jump
    |=> stack_reg[3'(sp_reg - 3'h1)] == $past(pc_reg))
    else $error("call pushed wrong address");
  a_alu_add: assert property (at_t4 && ex && cmd_in.op == OP_ADD
    |=> alu_wr_out && alu_result_out == 8'($past(cmd_in.opa) + $past(cmd_in.opb)))
    else $error("add result wrong");
  a_apb_wait: assert property (access && !pready_reg |=> pready_out)
    else $error("apb answer late");
  a_tmr0_vector: assert property (irq_ack_out == IRQ_TMR0 |-> pc_reg == VEC_TMR0)
    else $error("timer 0 vector wrong");
  a_return_pop: assert property (at_t4 && ex && !cmd_in.jump && !cmd_in.call
    && (cmd_in.return_from_call || cmd_in.return_from_interrupt)
    |=> pc_reg == stack_reg[sp_reg] && !valid_reg)
    else $error("return did not restore pc");
  a_full_call: assert property (at_t4 && ex && cmd_in.call && !cmd_in.jump && full
    |=> cnt_reg == STK_DEPTH && pc_reg == $past(cmd_in.target)
    && stack_reg[3'(sp_reg - 3'h1)] == $past(pc_reg))
    else $error("call on full stack misbehaved");
  a_pcl_read: assert property (access && !pready_reg && paddr_in == OFS_PCL
    |=> prdata_out == 32'($past(pc_reg) & 12'h0FF))
    else $error("pc low read wrong");
  a_reset_pc: assert property (disable iff (1'b0) !resetn_in
    |=> pc_reg == PC_RESET && cnt_reg == 4'h0 && !valid_reg)
    else $error("reset state wrong");
endmodule : pss_sequencer

// [tb/pss_sequencer_tb.sv]
// self-checking bench for the program sequencer
`timescale 1ns/100ps
module pss_sequencer_tb;
  import pss_pkg::*;
  logic mclk_in = 0;
  logic resetn_in = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] rd, prdata;
  logic [2:0] irq = 3'h0;
  logic [2:0] ack;
  logic pready, perr, ev, awr, amem, e;
  logic [11:0] pc, r;
  logic [14:0] ew;
  logic [3:0] ph;
  logic [7:0] ares;
  pss_cmd_s cmd = '0;
  int errors = 0;
  int check_count = 0;
  always #50 mclk_in = ~mclk_in;
  pss_sequencer pss_sequencer_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .prog_data_in({3'h0, pc}), .cmd_in(cmd), .irq_in(irq), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .prog_addr_out(pc), .exec_word_out(ew), .exec_valid_out(ev), .phase_out(ph),
    .alu_result_out(ares), .alu_wr_out(awr), .alu_to_mem_out(amem), .irq_ack_out(ack));

  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // f bits: 16 jump, 8 call, 4 return, 2 return from interrupt, 1 skip
  function automatic pss_cmd_s mk(int f, logic [11:0] t);
    pss_cmd_s k = '0;
    k.target = t;
    {k.jump, k.call, k.return_from_call, k.return_from_interrupt, k.skip} = f[4:0];
    return k;
  endfunction : mk

  // command must stand through the whole T4 cycle, so it goes up after the T3 edge
  task automatic cyc(pss_cmd_s k);
    do @(posedge mclk_in); while (ph !== PH_T3);
    cmd <= k;
    @(posedge mclk_in);
    cmd <= '0;
    #1;
  endtask : cyc

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge mclk_in);
    pen <= 1'b1;
    do @(posedge mclk_in); while (pready !== 1'b1);
    rd = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // waits a few slots for an acknowledge, then checks vector and pulse
  task automatic wack(logic [2:0] xa, logic [11:0] xp);
    for (int k = 0; k < 3; k++) begin
      cyc('0);
      if (ack !== 3'h0) break;
    end
    chk("ack", xa, ack);
    chk("vector", xp, pc);
  endtask : wack

  task automatic t_reset;
    chk("pc", 0, pc);
    apb(1'b0, OFS_SEQ_STAT, 0);
    chk("depth", 0, rd[3:0]);
    do @(posedge mclk_in); while (ph !== PH_T4);
    for (int i = 0; i < 8; i++) begin
      #1;
      chk("phase", 4'h1 << (i % 4), ph);
      @(posedge mclk_in);
    end
    // step past the T4 edge so the next test reads the settled pc
    #1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_seq;
    for (int i = 0; i < 3; i++) begin
      r = pc;
      cyc('0);
      chk("pc", r + 12'h1, pc);
      chk("word", r, ew[11:0]);
      chk("valid", 1, ev);
    end
    $display("test sequence done");
  endtask : t_seq

  task automatic t_branch;
    cyc(mk(16, 12'hA5C));
    chk("jump pc", 12'hA5C, pc);
    chk("jump dummy", 0, ev);
    cyc('0);
    chk("jump word", 12'hA5C, ew[11:0]);
    r = pc;
    cyc(mk(1, 12'h0));
    chk("skip dummy", 0, ev);
    cyc('0);
    chk("skip word", r + 12'h1, ew[11:0]);
    for (int i = 0; i < 2; i++) begin
      r = pc;
      cyc(mk(8, 12'h3F0));
      chk("call pc", 12'h3F0, pc);
      cyc('0);
      cyc(mk(4 >> i, 12'h0));
      chk("return pc", r, pc);
      cyc('0);
    end
    $display("test branch done");
  endtask : t_branch

  task automatic t_pcl;
    cyc(mk(16, 12'h3A0));
    cyc('0);
    apb(1'b1, OFS_PCL, 32'h55);
    cyc('0);
    chk("page load", 12'h355, pc);
    chk("load dummy", 0, ev);
    apb(1'b0, OFS_PCL, 0);
    chk("pcl read", 32'h0000_0055, rd);
    apb(1'b0, 8'hFC, 0);
    chk("unmapped", 1, e);
    $display("test pcl done");
  endtask : t_pcl

  task automatic t_irq;
    logic [11:0] vec [3] = '{VEC_USB, VEC_TMR0, VEC_TMR1};
    for (int i = 0; i < 3; i++) begin
      r = pc;
      @(posedge mclk_in);
      irq <= 3'h1 << i;
      @(posedge mclk_in);
      irq <= 3'h0;
      wack(3'h1 << i, vec[i]);
      cyc('0);
      cyc(mk(2, 12'h0));
      cyc('0);
    end
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_alu;
    pss_alu_op_e op [16] = '{OP_ADD, OP_ADC, OP_AND, OP_OR, OP_XOR, OP_ADD, OP_DAA, OP_SBC,
      OP_RRC, OP_RLC, OP_RR, OP_RL, OP_CPL, OP_INC, OP_DEC, OP_SUB};
    logic [7:0] a [16] = '{8'hF0, 8'h01, 8'hF0, 8'hF0, 8'hA5, 8'h15, 8'h3C, 8'h10,
      8'h01, 8'h80, 8'h01, 8'h80, 8'h5A, 8'hFF, 8'h00, 8'h10};
    logic [7:0] b [16] = '{8'h20, 8'h01, 8'h3C, 8'h0F, 8'hFF, 8'h27, 8'h00, 8'h05,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10};
    logic [7:0] x [16] = '{8'h10, 8'h03, 8'h30, 8'hFF, 8'h5A, 8'h3C, 8'h42, 8'h0A,
      8'h80, 8'h01, 8'h80, 8'h01, 8'hA5, 8'h00, 8'hFF, 8'h00};
    pss_cmd_s k;
    for (int i = 0; i < 16; i++) begin
      k = '0;
      k.op = op[i];
      k.opa = a[i];
      k.opb = b[i];
      k.to_mem = i[0];
      cyc(k);
      chk("alu result", x[i], ares);
      chk("alu write", 1, awr);
      chk("alu dest", i[0], amem);
    end
    apb(1'b0, OFS_ALU_STAT, 0);
    chk("zero flag", 1, rd[FLG_Z]);
    chk("carry flag", 1, rd[FLG_C]);
    $display("test alu done");
  endtask : t_alu

  task automatic t_full;
    for (int i = 0; i < 8; i++) begin
      cyc(mk(8, 12'h200 + 12'(i * 16)));
      cyc('0);
    end
    apb(1'b0, OFS_SEQ_STAT, 0);
    chk("depth", STK_DEPTH, rd[3:0]);
    @(posedge mclk_in);
    irq <= IRQ_USB;
    @(posedge mclk_in);
    irq <= 3'h0;
    for (int i = 0; i < 3; i++) begin
      cyc('0);
      chk("held ack", 0, ack);
    end
    r = pc;
    cyc(mk(8, 12'h700));
    chk("overflow call", 12'h700, pc);
    cyc('0);
    cyc(mk(4, 12'h0));
    chk("newest kept", r, pc);
    wack(IRQ_USB, VEC_USB);
    $display("test full stack done");
  endtask : t_full

  task automatic t_rerun;
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    #1;
    chk("reset pc", 0, pc);
    chk("reset valid", 0, ev);
    chk("reset phase", PH_T1, ph);
    apb(1'b0, OFS_SEQ_STAT, 0);
    chk("reset depth", 0, rd[7:0]);
    $display("test mid-run reset done");
  endtask : t_rerun

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // the whole run needs a few hundred cycles; this leaves a wide margin
  initial begin
    #2000000;
    errors++;
    results();
  end

  initial begin
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_seq();
    t_branch();
    t_pcl();
    t_irq();
    t_alu();
    t_full();
    t_rerun();
    results();
  end
endmodule : pss_sequencer_tb
